// ===== prgc_host_model.sv
// Host side model: register requests and pulled-up open-drain pins
`timescale 1ns/1ps

module prgc_host_model (
   input wire logic clk, // Clock
   output prgc_pkg::prgc_req_t req, // Request
   input wire logic [7:0] rdata, // Read data
   input wire logic rvalid, // Read valid
   input wire logic [3:0] gpio_oe, // Device pull-downs
   input wire logic [3:0] ext_low, // Outside pull-downs
   output logic [3:0] gpio_in // Resolved pins
);
   // Pull-up wins unless someone sinks the line
   assign gpio_in = ~(gpio_oe | ext_low);
   initial req = '0;
   // One-cycle write; supply-allow bit always kept set
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= {1'b1, 1'b0, a, (a == 8'h0C) ? (d | 8'h10) : d};
      @(negedge clk);
      req <= '0;
   endtask
   // One-cycle read; data taken while valid stands
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req <= {1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      req <= '0;
      d = rvalid ? rdata : 8'hXX;
   endtask
endmodule

// ===== prgc_ldo_ctrl.sv
// Mode decode for one linear regulator
`timescale 1ns/1ps

module prgc_ldo_ctrl (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic on_bit, // Enable bit
   input wire logic sleep_off_bit, // Off in sleep bit
   input wire logic sleep_active, // Low-power mode active
   output prgc_pkg::prgc_ldo_state_t state // Registered regulator state
);

   prgc_pkg::prgc_ldo_state_t state_reg, state_next;

   // -----------------------------------------------------------------
   // Enable and sleep combination
   // -----------------------------------------------------------------
   always_comb begin
      if (!on_bit) begin
         state_next = prgc_pkg::PRGC_LDO_OFF;
      end else if (!sleep_active) begin
         state_next = prgc_pkg::PRGC_LDO_FULL;
      end else if (sleep_off_bit) begin
         state_next = prgc_pkg::PRGC_LDO_OFF;
      end else begin
         state_next = prgc_pkg::PRGC_LDO_REDUCED;
      end
   end

   // Regulators are on after reset, matching the register defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= prgc_pkg::PRGC_LDO_FULL;
      end else begin
         state_reg <= state_next;
      end
   end

   assign state = state_reg;

endmodule

// ===== prgc_params.svh
// Register offsets, reset values, field positions and decode constants
`ifndef PRGC_PARAMS_SVH
`define PRGC_PARAMS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define PRGC_ADDR_MAIN 8'h0C
`define PRGC_ADDR_CORE 8'h0D
`define PRGC_ADDR_LREG 8'h0E
`define PRGC_ADDR_PIRQ 8'h0F
`define PRGC_ADDR_PDIR 8'h10

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define PRGC_RST_MAIN_HI 7'h39
`define PRGC_RST_CORE_S0 8'h68
`define PRGC_RST_CORE_S1 8'h78
`define PRGC_RST_LREG 8'h88
`define PRGC_RST_PIRQ 8'h00
`define PRGC_RST_PDIR 8'h00
`define PRGC_READ_NONE 8'h00

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define PRGC_MAIN_SUPPLY 4
`define PRGC_MAIN_SLPEN 3
`define PRGC_MAIN_DISCH 2
`define PRGC_CORE_OFFSLP 7
`define PRGC_CORE_VIB 1
`define PRGC_CORE_DISCH 0
`define PRGC_LREG_B_ON 7
`define PRGC_LREG_B_SOFF 6
`define PRGC_LREG_A_ON 3
`define PRGC_LREG_A_SOFF 2

// -----------------------------------------------------------------
// Misc
// -----------------------------------------------------------------
`define PRGC_PINS 4
`define PRGC_CODE_EXT 2'h0
`define PRGC_CODE_MSB0 1'h0

`endif

// ===== prgc_pin_edge.sv
// Synchroniser and edge detector for one general purpose input pin
`timescale 1ns/1ps

module prgc_pin_edge (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic pin_in, // Raw pin level
   input wire logic rising_sel, // 1 rising, 0 falling
   input wire logic armed, // Pin is input and unmasked
   output logic level, // Synchronised level
   output logic event_pulse // One-cycle edge event
);

   logic s1_reg, s1_next;
   logic s2_reg, s2_next;
   logic s3_reg, s3_next;
   logic ev_reg, ev_next;

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Two flops before use so a slow edge yields one event only
   always_comb begin
      s1_next = pin_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
      ev_next = armed & (rising_sel ? (s2_reg & ~s3_reg) : (~s2_reg & s3_reg));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         ev_reg <= 1'b0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         ev_reg <= ev_next;
      end
   end

   assign level = s2_reg;
   assign event_pulse = ev_reg;

endmodule

// ===== prgc_pkg.sv
// Types shared by the power rail and pin control register bank
package prgc_pkg;

   // Power state of one linear regulator
   typedef enum logic [1:0] {
      PRGC_LDO_OFF,
      PRGC_LDO_FULL,
      PRGC_LDO_REDUCED
   } prgc_ldo_state_t;

   // Rail controls handed to the analog side
   typedef struct packed {
      logic [1:0] main_voltage_code;
      logic [1:0] undervoltage_threshold_code;
      logic main_discharge_on;
      logic processor_rail_on;
      logic [2:0] processor_voltage_code;
      logic processor_discharge_on;
      logic vibrator_driver_on;
      prgc_ldo_state_t reg_a_state;
      logic [1:0] reg_a_voltage_code;
      logic reg_a_external;
      prgc_ldo_state_t reg_b_state;
      logic [1:0] reg_b_voltage_code;
   } prgc_rail_ctrl_t;

   // Register access from the serial protocol engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } prgc_req_t;

endpackage

// ===== prgc_regs.sv
// Register bank for rail control and general purpose pins
// Notes on behaviour
// - Main bit 3 gates whether the sleep request pin has effect.
// - Main bit 2 discharges main rail while main converter is disabled.
// - Main two-bit code picks 2.5/2.75/3.0/3.3 V; low bit from strap.
// - Core register resets to 68h or 78h per processor strap.
// - Core bit 7 switches processor converter off during sleep.
// - Three-bit processor code gives eight levels 0.85 V to 1.6 V.
// - In sleep, processor code is zero then two sleep bits, default 10.
// - Leaving sleep restores the full three-bit processor code.
// - Core bit 1 drives the vibrator transistor.
// - Core bit 0 discharges processor rail while that converter is off.
// - Regulator enable and sleep-off pick off, full or reduced power.
// - Regulator b code picks 1.8/2.5/2.75/3.0 V, resets to 00.
// - Regulator a code 00 is external setting, else 2.5/2.75/3.0 V.
// - Regulator register resets to 88h, both regulators on.
// - Raising regulator a by ten percent or more may force power-on reset.
// - Per-pin polarity bit chooses falling or rising interrupt edge.
// - Per-pin mask bits suppress interrupts; reset unmasked.
// - Direction bits make pins input or output; reset input.
// - Output value one pulls pin low through open drain.
// - Input value bits read pin level; writes to them ignored.
// - Undervoltage code picks 2.5/2.75/3.0/3.25 V, resets to 11.
`timescale 1ns/1ps
`include "prgc_params.svh"

module prgc_regs (
   input wire logic clk, // System clock, 50 MHz
   input wire logic rst, // Async reset, active high
   input prgc_pkg::prgc_req_t req, // Register request from serial engine
   output logic [7:0] rdata, // Registered read data
   output logic rvalid, // Read data valid pulse
   input wire logic main_default_strap, // Main voltage strap
   input wire logic processor_default_strap, // Processor voltage strap
   input wire logic sleep_request_pin, // Low-power request pin
   input wire logic main_converter_on, // Main converter running
   input wire logic [3:0] gpio_in, // Pin levels
   output logic [3:0] gpio_out, // Pin drive value, always low
   output logic [3:0] gpio_oe, // Pin pull-down enables
   output logic [3:0] gpio_event, // One-cycle edge events
   output logic reg_a_raise_big, // Regulator a raised ten percent or more
   output prgc_pkg::prgc_rail_ctrl_t rail // Rail controls
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [7:0] main_reg, main_next;
   logic [7:0] core_reg, core_next;
   logic [7:0] lreg_reg, lreg_next;
   logic [7:0] pirq_reg, pirq_next;
   logic [7:0] pdir_reg, pdir_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic strap_done_reg, strap_done_next;
   logic sleep_reg, sleep_next;
   logic raise_reg, raise_next;
   prgc_pkg::prgc_rail_ctrl_t rail_reg, rail_next;
   logic [3:0] pin_level;
   logic [3:0] pin_armed;
   prgc_pkg::prgc_ldo_state_t ldo_a_state;
   prgc_pkg::prgc_ldo_state_t ldo_b_state;
   logic sel_main, sel_core, sel_lreg, sel_pirq, sel_pdir;

   // Register layouts, high bit first:
   // main: spare, threshold code, supply-allow, sleep gate, discharge, voltage code
   // core: off in sleep, voltage code, sleep code, vibrator, discharge
   // lreg: b on, b sleep-off, b code, a on, a sleep-off, a code
   // pirq: rising-edge selects for pins 3..0, then masks for pins 3..0
   // pdir: directions for pins 3..0, then values; input values show the pin

   // Regulator a level in tenths of a volt order; external treated as lowest
   function automatic logic [1:0] prgc_ldo_a_rank(input logic [1:0] code);
      prgc_ldo_a_rank = code;
   endfunction

   // One-hot register select, main in bit 0 up to pin direction/value
   function automatic logic [4:0] prgc_sel(input logic [7:0] a);
      prgc_sel = 5'h00;
      if (a == `PRGC_ADDR_MAIN) begin
         prgc_sel = 5'h01;
      end else if (a == `PRGC_ADDR_CORE) begin
         prgc_sel = 5'h02;
      end else if (a == `PRGC_ADDR_LREG) begin
         prgc_sel = 5'h04;
      end else if (a == `PRGC_ADDR_PIRQ) begin
         prgc_sel = 5'h08;
      end else if (a == `PRGC_ADDR_PDIR) begin
         prgc_sel = 5'h10;
      end
   endfunction

   // Value bits that belong to output pins; input pins give zero
   function automatic logic [3:0] prgc_out_bits(input logic [7:0] dv);
      prgc_out_bits = dv[3:0] & dv[7:4];
   endfunction

   // Address decode shared by the write and the read path
   assign {sel_pdir, sel_pirq, sel_lreg, sel_core, sel_main} = prgc_sel(req.addr);

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   // Straps are caught on the first clock after reset release, since an
   // async reset may only load constants
   always_comb begin
      main_next = main_reg;
      core_next = core_reg;
      lreg_next = lreg_reg;
      pirq_next = pirq_reg;
      pdir_next = pdir_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg) begin
         main_next = {`PRGC_RST_MAIN_HI, main_default_strap};
         core_next = processor_default_strap ? `PRGC_RST_CORE_S1 : `PRGC_RST_CORE_S0;
      end else if (req.wr && sel_main) begin
         main_next = req.wdata;
      end else if (req.wr && sel_core) begin
         core_next = req.wdata;
      end else if (req.wr && sel_lreg) begin
         lreg_next = req.wdata;
      end else if (req.wr && sel_pirq) begin
         pirq_next = req.wdata;
      end else if (req.wr && sel_pdir) begin
         pdir_next[7:4] = req.wdata[7:4];
         // Only output pins keep a written value
         pdir_next[3:0] = prgc_out_bits(req.wdata);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         main_reg <= {`PRGC_RST_MAIN_HI, 1'b0};
         core_reg <= `PRGC_RST_CORE_S0;
         lreg_reg <= `PRGC_RST_LREG;
         pirq_reg <= `PRGC_RST_PIRQ;
         pdir_reg <= `PRGC_RST_PDIR;
         strap_done_reg <= 1'b0;
      end else begin
         main_reg <= main_next;
         core_reg <= core_next;
         lreg_reg <= lreg_next;
         pirq_reg <= pirq_next;
         pdir_reg <= pdir_next;
         strap_done_reg <= strap_done_next;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Input pins show the synchronised level instead of stored bits
   always_comb begin
      rvalid_next = req.rd;
      rdata_next = `PRGC_READ_NONE;
      if (sel_main) begin
         rdata_next = main_reg;
      end else if (sel_core) begin
         rdata_next = core_reg;
      end else if (sel_lreg) begin
         rdata_next = lreg_reg;
      end else if (sel_pirq) begin
         rdata_next = pirq_reg;
      end else if (sel_pdir) begin
         rdata_next[7:4] = pdir_reg[7:4];
         rdata_next[3:0] = prgc_out_bits(pdir_reg) | (pin_level & ~pdir_reg[7:4]);
      end
      if (!req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= `PRGC_READ_NONE;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // -----------------------------------------------------------------
   // Sleep mode
   // -----------------------------------------------------------------
   // Pin is synchronous to clk; registered once to align with rail outputs
   always_comb begin
      sleep_next = sleep_request_pin & main_reg[`PRGC_MAIN_SLPEN];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleep_reg <= 1'b0;
      end else begin
         sleep_reg <= sleep_next;
      end
   end

   // -----------------------------------------------------------------
   // Regulator a raise warning
   // -----------------------------------------------------------------
   // Every step up of the code is treated as a ten percent or larger rise; external
   // setting counts as the lowest, so leaving it warns while regulator a is on
   always_comb begin
      raise_next = lreg_reg[`PRGC_LREG_A_ON] &&
         (prgc_ldo_a_rank(lreg_next[1:0]) > prgc_ldo_a_rank(lreg_reg[1:0]));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         raise_reg <= 1'b0;
      end else begin
         raise_reg <= raise_next;
      end
   end

   // -----------------------------------------------------------------
   // Rail controls
   // -----------------------------------------------------------------
   // Rail view trails register and sleep state by one edge; regulator states by two
   always_comb begin
      rail_next = rail_reg;
      rail_next.main_voltage_code = main_reg[1:0];
      rail_next.undervoltage_threshold_code = main_reg[6:5];
      rail_next.main_discharge_on = main_reg[`PRGC_MAIN_DISCH] & ~main_converter_on;
      rail_next.processor_rail_on = ~(sleep_reg & core_reg[`PRGC_CORE_OFFSLP]);
      if (sleep_reg) begin
         rail_next.processor_voltage_code = {`PRGC_CODE_MSB0, core_reg[3:2]};
      end else begin
         rail_next.processor_voltage_code = core_reg[6:4];
      end
      rail_next.processor_discharge_on =
         core_reg[`PRGC_CORE_DISCH] & sleep_reg & core_reg[`PRGC_CORE_OFFSLP];
      rail_next.vibrator_driver_on = core_reg[`PRGC_CORE_VIB];
      rail_next.reg_a_state = ldo_a_state;
      rail_next.reg_a_voltage_code = lreg_reg[1:0];
      rail_next.reg_a_external = (lreg_reg[1:0] == `PRGC_CODE_EXT);
      rail_next.reg_b_state = ldo_b_state;
      rail_next.reg_b_voltage_code = lreg_reg[5:4];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rail_reg <= '0;
      end else begin
         rail_reg <= rail_next;
      end
   end

   // -----------------------------------------------------------------
   // Regulators
   // -----------------------------------------------------------------
   // Regulator a: enable and sleep-off bits in the low nibble
   prgc_ldo_ctrl u_ldo_a (
      .clk(clk),
      .rst(rst),
      .on_bit(lreg_reg[`PRGC_LREG_A_ON]),
      .sleep_off_bit(lreg_reg[`PRGC_LREG_A_SOFF]),
      .sleep_active(sleep_reg),
      .state(ldo_a_state)
   );

   // Regulator b: enable and sleep-off bits in the high nibble
   prgc_ldo_ctrl u_ldo_b (
      .clk(clk),
      .rst(rst),
      .on_bit(lreg_reg[`PRGC_LREG_B_ON]),
      .sleep_off_bit(lreg_reg[`PRGC_LREG_B_SOFF]),
      .sleep_active(sleep_reg),
      .state(ldo_b_state)
   );

   // -----------------------------------------------------------------
   // General purpose pins
   // -----------------------------------------------------------------
   // Mask set or pin driven as output disarms the edge detector
   assign pin_armed = ~pirq_reg[3:0] & ~pdir_reg[7:4];

   for (genvar i = 0; i < `PRGC_PINS; i++) begin : g_pin
      prgc_pin_edge u_edge (
         .clk(clk),
         .rst(rst),
         .pin_in(gpio_in[i]),
         .rising_sel(pirq_reg[4 + i]),
         .armed(pin_armed[i]),
         .level(pin_level[i]),
         .event_pulse(gpio_event[i])
      );
   end

   // Open drain: value one enables the pull-down on output pins
   assign gpio_out = 4'h0;
   assign gpio_oe = prgc_out_bits(pdir_reg);

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Data outputs come straight from their flops
   assign rdata = rdata_reg;
   assign rvalid = rvalid_reg;
   assign reg_a_raise_big = raise_reg;
   assign rail = rail_reg;

endmodule

// ===== prgc_regs_chk.sv
// Port-level checks for the rail and pin control register bank
`timescale 1ns/1ps

module prgc_regs_chk (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input prgc_pkg::prgc_req_t req, // Request
   input wire logic [7:0] rdata, // Read data
   input wire logic rvalid, // Read valid
   input wire logic main_default_strap, // Main strap
   input wire logic processor_default_strap, // Core strap
   input wire logic sleep_request_pin, // Sleep pin
   input wire logic main_converter_on, // Main running
   input wire logic [3:0] gpio_in, // Pins
   input wire logic [3:0] gpio_out, // Pin drive
   input wire logic [3:0] gpio_oe, // Pull-downs
   input wire logic [3:0] gpio_event, // Events
   input wire logic reg_a_raise_big, // Raise warning
   input prgc_pkg::prgc_rail_ctrl_t rail // Rails
);
   logic [7:0] main_m, core_m, irq_m, pd_m, lreg_m;
   logic first;
   logic [2:0] age;
   logic sl;
   assign sl = sleep_request_pin & main_m[3];
   // ------
   // Register mirrors; straps land on the first edge after release
   // ------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         main_m <= 8'h72;
         core_m <= 8'h68;
         lreg_m <= 8'h88;
         irq_m <= 8'h00;
         pd_m <= 8'h00;
         first <= 1'b1;
         age <= 3'h0;
      end else begin
         first <= 1'b0;
         age <= (age == 3'h7) ? age : age + 3'h1;
         if (first) begin
            main_m[0] <= main_default_strap;
            core_m[4] <= processor_default_strap;
         end else if (req.wr) begin
            case (req.addr)
               8'h0C: main_m <= req.wdata;
               8'h0D: core_m <= req.wdata;
               8'h0E: lreg_m <= req.wdata;
               8'h0F: irq_m <= req.wdata;
               8'h10: pd_m <= {req.wdata[7:4], req.wdata[7:4] & req.wdata[3:0]};
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_RD_CORE: assert property (req.rd && req.addr == 8'h0D |=> rvalid && rdata == $past(core_m))
      else $error("core read data wrong");
   AST_VCODE: assert property (age == 3'h7 |-> rail.processor_voltage_code ==
      ($past(sl, 2) ? {1'b0, $past(core_m[3:2])} : $past(core_m[6:4])))
      else $error("processor voltage code wrong");
   AST_CORE_OFF: assert property (age == 3'h7 |->
      rail.processor_rail_on == !($past(sl, 2) && $past(core_m[7])))
      else $error("processor rail on wrong");
   AST_CORE_DIS: assert property (age == 3'h7 |->
      rail.processor_discharge_on == ($past(core_m[0]) && !rail.processor_rail_on))
      else $error("processor discharge wrong");
   AST_VIB: assert property (age == 3'h7 |-> rail.vibrator_driver_on == $past(core_m[1]))
      else $error("vibrator drive wrong");
   AST_MAIN: assert property (age == 3'h7 |-> {rail.main_voltage_code,
      rail.undervoltage_threshold_code} == {$past(main_m[1:0]), $past(main_m[6:5])})
      else $error("main codes wrong");
   AST_MAIN_DIS: assert property (age == 3'h7 |->
      rail.main_discharge_on == ($past(main_m[2]) && !$past(main_converter_on)))
      else $error("main discharge wrong");
   AST_OD: assert property (gpio_oe == (pd_m[7:4] & pd_m[3:0]) && gpio_out == 4'h0)
      else $error("pin pull-down wrong");
   AST_EDGE: assert property (age == 3'h7 |-> gpio_event ==
      (~$past(pd_m[7:4]) & ~$past(irq_m[3:0]) &
      (($past(irq_m[7:4]) & $past(gpio_in, 3) & ~$past(gpio_in, 4)) |
      (~$past(irq_m[7:4]) & ~$past(gpio_in, 3) & $past(gpio_in, 4)))))
      else $error("pin event wrong");
   AST_LREG: assert property (age == 3'h7 |-> {rail.reg_b_voltage_code,
      rail.reg_a_voltage_code, rail.reg_a_external} ==
      {$past(lreg_m[5:4]), $past(lreg_m[1:0]), $past(lreg_m[1:0]) == 2'h0})
      else $error("regulator codes wrong");
   AST_RAISE: assert property (!first |=> reg_a_raise_big ==
      $past(req.wr && req.addr == 8'h0E && lreg_m[3] && req.wdata[1:0] > lreg_m[1:0]))
      else $error("regulator a raise warning wrong");
endmodule

bind prgc_regs prgc_regs_chk prgc_regs_chk_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
   .rvalid(rvalid), .main_default_strap(main_default_strap),
   .processor_default_strap(processor_default_strap), .sleep_request_pin(sleep_request_pin),
   .main_converter_on(main_converter_on), .gpio_in(gpio_in), .gpio_out(gpio_out),
   .gpio_oe(gpio_oe), .gpio_event(gpio_event), .reg_a_raise_big(reg_a_raise_big),
   .rail(rail));

// ===== testbench.sv
// Self-checking bench for the rail and pin control register bank
`timescale 1ns/1ps

module testbench;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} prgc_row_t;
   logic clk, rst, mstrap, pstrap, sleep_pin, mconv_on, rvalid;
   logic [3:0] ext_low, gpio_in, gpio_oe, gpio_event;
   logic [7:0] rdata, got;
   logic [7:0] rexp [5];
   logic [8:0] rv;
   prgc_pkg::prgc_req_t req;
   prgc_pkg::prgc_rail_ctrl_t rail;
   int num_errors = 0;
   int n_tests = 0;
   // Plain write/readback rows; the host does not wait when codes move
   prgc_row_t rows [10] = '{'{8'h0D, 8'hA5, 8'hA5}, '{8'h0D, 8'h4A, 8'h4A},
      '{8'h0E, 8'h00, 8'h00}, '{8'h0E, 8'h37, 8'h37}, '{8'h0E, 8'hBB, 8'hBB},
      '{8'h0F, 8'h5A, 8'h5A}, '{8'h10, 8'h3F, 8'h3F}, '{8'h10, 8'h30, 8'h3C},
      '{8'h0C, 8'h0B, 8'h1B}, '{8'h11, 8'hFF, 8'h00}};
   assign rv = {rail.processor_rail_on, rail.main_discharge_on, rail.reg_a_state,
      rail.reg_b_state, rail.processor_voltage_code};

   prgc_regs prgc_regs_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .main_default_strap(mstrap), .processor_default_strap(pstrap),
      .sleep_request_pin(sleep_pin), .main_converter_on(mconv_on), .gpio_in(gpio_in),
      .gpio_out(), .gpio_oe(gpio_oe), .gpio_event(gpio_event), .reg_a_raise_big(),
      .rail(rail));
   prgc_host_model prgc_host_model_i (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid),
      .gpio_oe(gpio_oe), .ext_low(ext_low), .gpio_in(gpio_in));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic do_reset(input logic s);
      mstrap = s;
      pstrap = s;
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // Rail view settles up to three edges after its cause; four gives margin
   task automatic rail_chk(input logic [8:0] exp);
      repeat (4) @(negedge clk);
      check("rail view", {7'h00, rv}, {7'h00, exp});
   endtask

   // Collect which pins fire and count all pulses together; each edge must give exactly one
   task automatic pin_step(input logic [3:0] low, input logic [3:0] exp);
      logic [3:0] seen;
      int cnt;
      seen = 4'h0;
      cnt = 0;
      ext_low = low;
      repeat (8) begin
         @(negedge clk);
         seen = seen | gpio_event;
         cnt = cnt + $countones(gpio_event);
      end
      check("pin events", {8'h00, seen, 4'(cnt)}, {8'h00, exp, 4'($countones(exp))});
   endtask

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      req = '0;
      sleep_pin = 1'b0;
      mconv_on = 1'b1;
      ext_low = 4'h0;
      do_reset(1'b0);
      foreach (rows[i]) begin
         prgc_host_model_i.wr_reg(rows[i].a, rows[i].d);
         prgc_host_model_i.rd_reg(rows[i].a, got);
         check("readback", {8'h00, got}, {8'h00, rows[i].e});
      end
      // Reset values under both strap settings; idle pins read high
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         rexp = '{{7'h39, s[0]}, (s[0] ? 8'h78 : 8'h68), 8'h88, 8'h00, 8'h0F};
         for (int j = 0; j < 5; j++) begin
            prgc_host_model_i.rd_reg(8'h0C + j[7:0], got);
            check("reset value", {8'h00, got}, {8'h00, rexp[j]});
         end
      end
      // Sleep entry, core-off toggle, exit, then sleep pin gated off
      prgc_host_model_i.wr_reg(8'h0E, 8'hC8);
      prgc_host_model_i.wr_reg(8'h0E, 8'hC9);
      prgc_host_model_i.wr_reg(8'h0D, 8'hED);
      prgc_host_model_i.wr_reg(8'h0C, 8'h1C);
      mconv_on = 1'b0;
      sleep_pin = 1'b1;
      rail_chk({2'b01, prgc_pkg::PRGC_LDO_REDUCED, prgc_pkg::PRGC_LDO_OFF, 3'h3});
      prgc_host_model_i.wr_reg(8'h0D, 8'h6D);
      rail_chk({2'b11, prgc_pkg::PRGC_LDO_REDUCED, prgc_pkg::PRGC_LDO_OFF, 3'h3});
      sleep_pin = 1'b0;
      mconv_on = 1'b1;
      rail_chk({2'b10, prgc_pkg::PRGC_LDO_FULL, prgc_pkg::PRGC_LDO_FULL, 3'h6});
      prgc_host_model_i.wr_reg(8'h0C, 8'h10);
      sleep_pin = 1'b1;
      rail_chk({2'b10, prgc_pkg::PRGC_LDO_FULL, prgc_pkg::PRGC_LDO_FULL, 3'h6});
      sleep_pin = 1'b0;
      // Pin 0 rising, others falling, pin 2 masked; later pin 3 output
      prgc_host_model_i.wr_reg(8'h0F, 8'h14);
      pin_step(4'hF, 4'hA);
      pin_step(4'h0, 4'h1);
      prgc_host_model_i.wr_reg(8'h10, 8'h80);
      pin_step(4'hF, 4'h2);
      pin_step(4'h0, 4'h1);
      wrap_up();
   end
endmodule
